// ===== sis_pkg.sv
// What this block does
// - a per-terminal diagnosis bit decides whether the assigned test output pulses; when off, no pulse check is made.
// - with diagnosis on, each terminal uses a selectable test output as its source, defaulting to its own index.
// - with diagnosis on, a per-terminal mode picks one of four test waveforms: contact, beam sensor, door switch, mat.
// - in contact mode the pulse returns through the contact, and a line held high during the pulse is an error.
// - each terminal pair picks single, dual equivalent, dual complementary or mat/edge evaluation.
// - dual operation pairs even terminal n with n+1 and compares the two levels.
// - in a dual mode a change on one input starts a timer, and an error is raised if the other does not follow in time.
// - discrepancy codes 1 to 8 give 500 ms doubling up to 64000 ms.
// - a pair in single evaluation takes no discrepancy setting, and no discrepancy timing runs.
// - in single evaluation each terminal's data equals its evaluated level while no test pulse error is shown for it, and is 0 while one is.
// - dual equivalent gives 1 only for 11; the patterns 01 and 10 are discrepant.
// - dual complementary gives 1 for 10 and 0 for 01; the patterns 00 and 11 give 0 and are discrepant.
// - in any paired mode the odd terminal's data is held at 0, and the consumer reads the even one.
// - in mat/edge evaluation the even data is 1 without load and 0 under load.
// - a test pulse or discrepancy error stays visible in status and indicators for at least one second.
package sis_pkg;
  localparam int CLK_MHZ = 100;
  localparam int NUM_TEST = 4;
  localparam int CNT_W = 40;
  // register byte offsets
  localparam logic [7:0] OFF_TERM_CFG = 8'h00;
  localparam logic [7:0] OFF_PAIR_CFG = 8'h04;
  localparam logic [7:0] OFF_DATA = 8'h08;
  localparam logic [7:0] OFF_ERR = 8'h0C;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
  // field layout: one byte per terminal or pair in the config words
  localparam int CFG_STRIDE = 8;
  localparam int TERM_CFG_W = 5;
  localparam int DISC_LSB = 4;
  localparam int DATA_LVL_LSB = 8;
  localparam int ERR_DISC_LSB = 16;
  localparam int IRQ_DISC_LSB = 8;
  localparam logic [31:0] TERM_CFG_RST = 32'h1911_0901;
  localparam logic [31:0] PAIR_CFG_RST = 32'h1010_1010;
  localparam logic [31:0] IRQ_MASK_RST = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] DISC_CODE_MIN = 4'h1;
  localparam logic [3:0] DISC_CODE_MAX = 4'h8;
  // test pulse timing
  localparam int TP_PERIOD_US = 40;
  localparam int TP_PERIOD_CYC = TP_PERIOD_US * CLK_MHZ;
  localparam int TP_SLOT_CYC = TP_PERIOD_CYC / NUM_TEST;
  localparam int TP_LOW_MECH_US = 1;
  localparam int TP_LOW_BEAM_US = 4;
  localparam int TP_LOW_DOOR_US = 2;
  localparam int TP_LOW_MAT_US = 6;
  // error hold and discrepancy base time
  localparam longint HOLD_MS = 1000;
  localparam longint HOLD_CYC = HOLD_MS * 1000 * CLK_MHZ;
  localparam longint DISC_BASE_MS = 500;
  localparam longint DISC_BASE_CYC = DISC_BASE_MS * 1000 * CLK_MHZ;

  typedef enum logic [1:0] {TP_MECH, TP_BEAM, TP_DOOR, TP_MAT} sis_tp_mode_e;
  typedef enum logic [1:0] {EV_SINGLE, EV_EQUIV, EV_COMPL, EV_MAT} sis_eval_e;

  typedef struct packed {
    logic [1:0] src;
    sis_tp_mode_e mode;
    logic diag;
  } sis_term_cfg_s;

  // low time of one test pulse for a waveform
  function automatic logic [15:0] tpLowCyc(input sis_tp_mode_e mode);
    unique case (mode)
      TP_MECH: tpLowCyc = 16'(TP_LOW_MECH_US * CLK_MHZ);
      TP_BEAM: tpLowCyc = 16'(TP_LOW_BEAM_US * CLK_MHZ);
      TP_DOOR: tpLowCyc = 16'(TP_LOW_DOOR_US * CLK_MHZ);
      TP_MAT: tpLowCyc = 16'(TP_LOW_MAT_US * CLK_MHZ);
    endcase
  endfunction

  // code n gives base shifted by n-1, each step doubling
  function automatic logic [CNT_W-1:0] discLimit(input logic [CNT_W-1:0] base, input logic [3:0] code);
    discLimit = base << (code - DISC_CODE_MIN);
  endfunction
endpackage

// ===== sis_err_hold.sv
`timescale 1ns/1ps
// stretches an error level so it stays shown for a minimum time after it goes away
module sis_err_hold #(
  parameter int CNT_W = 40
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [CNT_W-1:0] holdCyc,
  input wire logic errNow,
  output logic errShown
);
  logic [CNT_W-1:0] cnt;
  wire holdDone = (cnt >= holdCyc - CNT_W'(1));

  // counting restarts whenever the error is still present
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      errShown <= 1'b0;
    end else begin
      cnt <= (errNow || !errShown) ? '0 : cnt + CNT_W'(1);
      if (errNow) begin
        errShown <= 1'b1;
      end else if (holdDone) begin
        errShown <= 1'b0;
      end
    end
  end

  property p_hold_min;
    @(posedge core_clk) disable iff (rst)
    $fell(errShown) |-> $past(cnt) >= holdCyc - CNT_W'(1);
  endproperty
  a_hold_min: assert property (p_hold_min) else $error("error status released before hold time");
endmodule

// ===== sis_pair_eval.sv
`timescale 1ns/1ps
// dual channel evaluation and discrepancy timing for one terminal pair
module sis_pair_eval #(
  parameter int CNT_W = 40
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire sis_pkg::sis_eval_e evalMode,
  input wire logic [CNT_W-1:0] discLim,
  input wire logic lvlEven,
  input wire logic lvlOdd,
  input wire logic tpErr,
  output logic dataEven,
  output logic discErr
);
  typedef enum logic [1:0] {PR_OK, PR_WAIT, PR_FAULT} sis_pair_state_e;
  sis_pair_state_e state;
  logic [CNT_W-1:0] cnt;

  // discrepancy timing only applies to the two dual modes
  wire isDual = (evalMode == sis_pkg::EV_EQUIV) || (evalMode == sis_pkg::EV_COMPL);
  wire consistent = (evalMode == sis_pkg::EV_COMPL) ? (lvlEven != lvlOdd) : (lvlEven == lvlOdd);
  wire restPattern = (evalMode == sis_pkg::EV_COMPL) ? (!lvlEven && lvlOdd) : (!lvlEven && !lvlOdd);
  wire expired = (cnt >= discLim - CNT_W'(1));
  // truth tables; discrepant patterns yield 0
  wire rawData = (evalMode == sis_pkg::EV_COMPL) ? (lvlEven && !lvlOdd) : (lvlEven && lvlOdd);
  wire next_dataEven = rawData && !tpErr && (state != PR_FAULT);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= PR_OK;
      cnt <= '0;
      dataEven <= 1'b0;
      discErr <= 1'b0;
    end else begin
      dataEven <= next_dataEven;
      discErr <= (state == PR_FAULT);
      cnt <= (state == PR_WAIT) ? cnt + CNT_W'(1) : '0;
      unique case (state)
        PR_OK: if (isDual && !consistent) state <= PR_WAIT;
        PR_WAIT: begin
          if (!isDual || consistent) state <= PR_OK;
          else if (expired) state <= PR_FAULT;
        end
        PR_FAULT: if (!isDual || restPattern) state <= PR_OK;
      endcase
    end
  end

  property p_disc_trip;
    @(posedge core_clk) disable iff (rst)
    (state == PR_WAIT && isDual && !consistent && expired) |=> (state == PR_FAULT) ##1 discErr;
  endproperty
  a_disc_trip: assert property (p_disc_trip) else $error("discrepancy timeout did not raise error");

  property p_fault_data0;
    @(posedge core_clk) disable iff (rst)
    (state == PR_FAULT) |=> !dataEven;
  endproperty
  a_fault_data0: assert property (p_fault_data0) else $error("pair data active during discrepancy fault");

  property p_equiv_table;
    @(posedge core_clk) disable iff (rst)
    (evalMode == sis_pkg::EV_EQUIV && lvlEven != lvlOdd) |=> !dataEven;
  endproperty
  a_equiv_table: assert property (p_equiv_table) else $error("equivalent pair active on mixed inputs");

  property p_compl_table;
    @(posedge core_clk) disable iff (rst)
    (evalMode == sis_pkg::EV_COMPL && lvlEven == lvlOdd) |=> !dataEven;
  endproperty
  a_compl_table: assert property (p_compl_table) else $error("complementary pair active on equal inputs");
endmodule

// ===== sis_safety_in.sv
// The register offsets and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
// safety input evaluation: test pulses, pulse check, pair evaluation, error hold, AXI4-Lite registers
module sis_safety_in #(
  parameter int NUM_TERM = 4,
  parameter int ADDR_W = 8,
  parameter logic [39:0] HOLD_CYC = 40'(sis_pkg::HOLD_CYC),
  parameter logic [39:0] DISC_BASE_CYC = 40'(sis_pkg::DISC_BASE_CYC)
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NUM_TERM-1:0] siIn,
  output logic [sis_pkg::NUM_TEST-1:0] testOut,
  output logic [NUM_TERM-1:0] safeData,
  output logic [NUM_TERM-1:0] ledYellow,
  output logic [NUM_TERM-1:0] ledRed,
  output logic irq
);
  localparam int NT = sis_pkg::NUM_TEST;
  localparam int NP = NUM_TERM / 2;
  localparam int CW = sis_pkg::CNT_W;

  // merge written bytes into an old word
  function automatic logic [31:0] strbMerge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] strb);
    for (int b = 0; b < 4; b++) begin
      strbMerge[b*8 +: 8] = strb[b] ? wd[b*8 +: 8] : old[b*8 +: 8];
    end
  endfunction

  // a discrepancy code is kept only for a dual pair and only when it is a legal code
  function automatic logic [31:0] pairFilter(input logic [31:0] old, input logic [31:0] wd);
    logic [3:0] code;
    logic [1:0] ev;
    pairFilter = wd;
    for (int p = 0; p < 4; p++) begin
      code = wd[p*sis_pkg::CFG_STRIDE + sis_pkg::DISC_LSB +: 4];
      ev = wd[p*sis_pkg::CFG_STRIDE +: 2];
      if (ev == 2'(sis_pkg::EV_SINGLE) || ev == 2'(sis_pkg::EV_MAT)
          || code < sis_pkg::DISC_CODE_MIN || code > sis_pkg::DISC_CODE_MAX) begin
        pairFilter[p*sis_pkg::CFG_STRIDE + sis_pkg::DISC_LSB +: 4] =
          old[p*sis_pkg::CFG_STRIDE + sis_pkg::DISC_LSB +: 4];
      end
    end
  endfunction

  logic [31:0] termCfgReg;
  logic [31:0] pairCfgReg;
  logic [31:0] irqStat;
  logic [31:0] irqMask;
  logic [15:0] periodCnt;
  logic [NT-1:0] testOutD;
  logic [NUM_TERM-1:0] lvl;
  logic [NUM_TERM-1:0] tpErrNow;
  logic [NUM_TERM-1:0] tpShown;
  logic [NUM_TERM-1:0] tpShownD;
  logic [NP-1:0] discErr;
  logic [NP-1:0] discShown;
  logic [NP-1:0] discShownD;
  logic [NP-1:0] pairData;

  sis_pkg::sis_term_cfg_s termCfg [NUM_TERM];
  sis_pkg::sis_eval_e pairEval [NP];
  logic [NP-1:0] pairUsed;
  logic [NT-1:0] tpUse;
  logic [NT-1:0] tpLow;
  logic [NT-1:0] tpSample;
  logic [NUM_TERM-1:0] freeze;
  logic [NUM_TERM-1:0] sampleHit;
  logic [NUM_TERM-1:0] next_safeData;
  logic [NUM_TERM-1:0] next_ledRed;

  // bus decode: both write channels must be present, one transfer at a time
  wire wrGo = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  wire rdGo = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  wire [7:0] wrOff = 8'({s_axi_awaddr[ADDR_W-1:2], 2'b00});
  wire [7:0] rdOff = 8'({s_axi_araddr[ADDR_W-1:2], 2'b00});
  wire wrTerm = wrGo && (wrOff == sis_pkg::OFF_TERM_CFG);
  wire wrPair = wrGo && (wrOff == sis_pkg::OFF_PAIR_CFG);
  wire wrStat = wrGo && (wrOff == sis_pkg::OFF_IRQ_STAT);
  wire wrMask = wrGo && (wrOff == sis_pkg::OFF_IRQ_MASK);
  wire wrHit = wrTerm || wrPair || wrStat || wrMask;
  wire [31:0] wrBits = strbMerge(32'h0000_0000, s_axi_wdata, s_axi_wstrb);
  wire [31:0] dataWord = 32'(safeData) | (32'(lvl) << sis_pkg::DATA_LVL_LSB);
  wire [31:0] errWord = 32'(tpShown) | (32'(discShown) << sis_pkg::ERR_DISC_LSB);
  wire rdHit = (rdOff == sis_pkg::OFF_TERM_CFG) || (rdOff == sis_pkg::OFF_PAIR_CFG)
               || (rdOff == sis_pkg::OFF_DATA) || (rdOff == sis_pkg::OFF_ERR)
               || (rdOff == sis_pkg::OFF_IRQ_STAT) || (rdOff == sis_pkg::OFF_IRQ_MASK);
  wire [31:0] rdMux = (rdOff == sis_pkg::OFF_TERM_CFG) ? termCfgReg :
                      (rdOff == sis_pkg::OFF_PAIR_CFG) ? pairCfgReg :
                      (rdOff == sis_pkg::OFF_DATA) ? dataWord :
                      (rdOff == sis_pkg::OFF_ERR) ? errWord :
                      (rdOff == sis_pkg::OFF_IRQ_STAT) ? irqStat :
                      (rdOff == sis_pkg::OFF_IRQ_MASK) ? irqMask : 32'h0000_0000;
  // events are rising edges of the held error status
  wire [31:0] irqEvent = 32'(tpShown & ~tpShownD) | (32'(discShown & ~discShownD) << sis_pkg::IRQ_DISC_LSB);
  wire [31:0] irqClr = wrStat ? wrBits : 32'h0000_0000;
  // set wins over a clear in the same cycle
  wire [31:0] next_irqStat = (irqStat & ~irqClr) | irqEvent;

  // write channel and register file
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= sis_pkg::RESP_OKAY;
      termCfgReg <= sis_pkg::TERM_CFG_RST;
      pairCfgReg <= sis_pkg::PAIR_CFG_RST;
      irqMask <= sis_pkg::IRQ_MASK_RST;
    end else begin
      s_axi_awready <= wrGo;
      s_axi_wready <= wrGo;
      if (wrGo) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wrHit ? sis_pkg::RESP_OKAY : sis_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wrTerm) termCfgReg <= strbMerge(termCfgReg, s_axi_wdata, s_axi_wstrb);
      if (wrPair) pairCfgReg <= pairFilter(pairCfgReg, strbMerge(pairCfgReg, s_axi_wdata, s_axi_wstrb));
      if (wrMask) irqMask <= strbMerge(irqMask, s_axi_wdata, s_axi_wstrb);
    end
  end

  // read channel; unmapped offsets read zero with an error response
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= sis_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= rdGo;
      if (rdGo) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdMux;
        s_axi_rresp <= rdHit ? sis_pkg::RESP_OKAY : sis_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // interrupt status, sticky until a one is written back
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irqStat <= 32'h0000_0000;
      irq <= 1'b0;
      tpShownD <= '0;
      discShownD <= '0;
    end else begin
      irqStat <= next_irqStat;
      irq <= |(next_irqStat & irqMask);
      tpShownD <= tpShown;
      discShownD <= discShown;
    end
  end

  // configuration views and pair usage
  always_comb begin
    for (int i = 0; i < NUM_TERM; i++) begin
      termCfg[i] = sis_pkg::sis_term_cfg_s'(termCfgReg[i*sis_pkg::CFG_STRIDE +: sis_pkg::TERM_CFG_W]);
    end
    for (int p = 0; p < NP; p++) begin
      pairEval[p] = sis_pkg::sis_eval_e'(pairCfgReg[p*sis_pkg::CFG_STRIDE +: 2]);
      pairUsed[p] = (pairEval[p] != sis_pkg::EV_SINGLE);
    end
  end

  // each test output pulses in its own slot so shorts between sources show up;
  // the waveform follows the last enabled terminal that selects the output
  always_comb begin
    sis_pkg::sis_tp_mode_e mode;
    logic [15:0] start;
    logic [15:0] width;
    mode = sis_pkg::TP_MECH;
    start = '0;
    width = '0;
    for (int j = 0; j < NT; j++) begin
      tpUse[j] = 1'b0;
      mode = sis_pkg::TP_MECH;
      for (int i = 0; i < NUM_TERM; i++) begin
        if (termCfg[i].diag && termCfg[i].src == 2'(j)) begin
          tpUse[j] = 1'b1;
          mode = termCfg[i].mode;
        end
      end
      start = 16'(j * sis_pkg::TP_SLOT_CYC);
      width = sis_pkg::tpLowCyc(mode);
      tpLow[j] = tpUse[j] && (periodCnt >= start) && (periodCnt < start + width);
      tpSample[j] = tpUse[j] && (periodCnt == start + width);
    end
  end

  // test pulse period and outputs; an unused output stays high
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      periodCnt <= '0;
      testOut <= '1;
      testOutD <= '1;
    end else begin
      periodCnt <= (periodCnt == 16'(sis_pkg::TP_PERIOD_CYC - 1)) ? '0 : periodCnt + 16'h0001;
      testOut <= ~tpLow;
      testOutD <= testOut;
    end
  end

  // per terminal: the level freezes around its source pulse so the pulse never reaches the data
  always_comb begin
    for (int i = 0; i < NUM_TERM; i++) begin
      freeze[i] = termCfg[i].diag && (tpLow[termCfg[i].src] || !testOut[termCfg[i].src]
                  || !testOutD[termCfg[i].src]);
      sampleHit[i] = termCfg[i].diag && tpSample[termCfg[i].src];
    end
  end

  // evaluated level and pulse check: an input that stays high while its source is low is stuck,
  // touching supply or shorted to another line
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lvl <= '0;
      tpErrNow <= '0;
    end else begin
      for (int i = 0; i < NUM_TERM; i++) begin
        if (!freeze[i]) lvl[i] <= siIn[i];
        if (!termCfg[i].diag) begin
          tpErrNow[i] <= 1'b0;
        end else if (sampleHit[i]) begin
          tpErrNow[i] <= siIn[i];
        end
      end
    end
  end

  // error hold per terminal and pair evaluation per pair
  for (genvar i = 0; i < NUM_TERM; i++) begin : g_term
    sis_err_hold #(.CNT_W(CW)) uTpHold (
      .core_clk(core_clk),
      .rst(rst),
      .holdCyc(HOLD_CYC),
      .errNow(tpErrNow[i]),
      .errShown(tpShown[i])
    );
  end
  for (genvar p = 0; p < NP; p++) begin : g_pair
    sis_pair_eval #(.CNT_W(CW)) uPair (
      .core_clk(core_clk),
      .rst(rst),
      .evalMode(pairEval[p]),
      .discLim(sis_pkg::discLimit(DISC_BASE_CYC, pairCfgReg[p*sis_pkg::CFG_STRIDE + sis_pkg::DISC_LSB +: 4])),
      .lvlEven(lvl[2*p]),
      .lvlOdd(lvl[2*p+1]),
      .tpErr(tpShown[2*p] || tpShown[2*p+1]),
      .dataEven(pairData[p]),
      .discErr(discErr[p])
    );
    sis_err_hold #(.CNT_W(CW)) uDiscHold (
      .core_clk(core_clk),
      .rst(rst),
      .holdCyc(HOLD_CYC),
      .errNow(discErr[p]),
      .errShown(discShown[p])
    );
  end

  // safety data and red indicators
  always_comb begin
    for (int i = 0; i < NUM_TERM; i++) begin
      if (!pairUsed[i/2]) begin
        next_safeData[i] = lvl[i] && !tpShown[i];
      end else if (i % 2 == 0) begin
        next_safeData[i] = pairData[i/2];
      end else begin
        next_safeData[i] = 1'b0;
      end
      next_ledRed[i] = tpShown[i] || discShown[i/2];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      safeData <= '0;
      ledYellow <= '0;
      ledRed <= '0;
    end else begin
      safeData <= next_safeData;
      ledYellow <= lvl;
      ledRed <= next_ledRed;
    end
  end

  property p_idle_high;
    @(posedge core_clk) disable iff (rst)
    ##1 ((~$past(tpUse) & ~testOut) == '0);
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("test output pulsed with no diagnosing terminal");

  property p_stuck_high;
    @(posedge core_clk) disable iff (rst)
    (sampleHit[0] && siIn[0]) |=> tpErrNow[0] ##1 tpShown[0] ##2 !safeData[0] && ledRed[0];
  endproperty
  a_stuck_high: assert property (p_stuck_high) else $error("stuck input not flagged on terminal 0");

  property p_odd_zero;
    @(posedge core_clk) disable iff (rst)
    pairUsed[0] |=> !safeData[1];
  endproperty
  a_odd_zero: assert property (p_odd_zero) else $error("odd terminal data not held low in paired mode");

  property p_single_data;
    @(posedge core_clk) disable iff (rst)
    (!pairUsed[0] && !tpShown[0]) |=> safeData[0] == $past(lvl[0]);
  endproperty
  a_single_data: assert property (p_single_data) else $error("single channel data differs from level");

  property p_single_disc;
    @(posedge core_clk) disable iff (rst)
    (wrPair && s_axi_wstrb[0] && s_axi_wdata[1:0] == 2'(sis_pkg::EV_SINGLE))
      |=> $stable(pairCfgReg[sis_pkg::DISC_LSB +: 4]);
  endproperty
  a_single_disc: assert property (p_single_disc) else $error("discrepancy code changed in single mode");
endmodule

// ===== sis_switch_model.sv
`timescale 1ns/1ps
// far-side switches: a closed contact loops its own test output back to its input
module sis_switch_model (
  input wire logic [3:0] testOut,
  input wire logic [3:0] closed,
  input wire logic [3:0] stuck,
  output logic [3:0] siIn
);
  // a stuck line ignores the pulse, which is exactly the fault the pulse check must catch
  assign siIn = stuck | (closed & testOut);
endmodule

// ===== sis_safety_in_tb.sv
`timescale 1ns/1ps
module sis_safety_in_tb;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_rdata, rd;
  logic [3:0] testOut, siIn, safeData, ledYellow, ledRed;
  logic [3:0] closed = 4'h0;
  logic [3:0] stuck = 4'h0;
  // rows: eval mode, levels {odd, even}, expected data {odd, even}
  logic [5:0] rows [8] = '{6'h05, 6'h0A, 6'h1D, 6'h18, 6'h25, 6'h28, 6'h3D, 6'h34};
  int num_errors = 0;
  int compares = 0;
  int lowCnt = 0;

  sis_safety_in #(.HOLD_CYC(40'h14), .DISC_BASE_CYC(40'h8)) dut (.core_clk(core_clk), .rst(rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .siIn(siIn), .testOut(testOut), .safeData(safeData),
    .ledYellow(ledYellow), .ledRed(ledRed), .irq(irq));
  sis_switch_model partner (.testOut(testOut), .closed(closed), .stuck(stuck), .siIn(siIn));

  always #5 core_clk = ~core_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // each channel is released at the edge where its ready is seen; bready stays up until bvalid
  task automatic axiWrite(input logic [7:0] addr, input logic [31:0] data, output logic [1:0] rsp);
    int n;
    n = 0;
    s_axi_awaddr <= addr;
    s_axi_wdata <= data;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    rsp = 2'h3;
    while (rsp === 2'h3 && n < 100) begin
      @(posedge core_clk);
      n++;
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) begin
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
    if (rsp === 2'h3) num_errors++;
    @(posedge core_clk); // an edge between transfers so no signal is driven twice in one step
  endtask

  task automatic axiRead(input logic [7:0] addr, output logic [31:0] data, output logic [1:0] rsp);
    int n;
    n = 0;
    s_axi_araddr <= addr;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    rsp = 2'h3;
    while (rsp === 2'h3 && n < 100) begin
      @(posedge core_clk);
      n++;
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) begin
        rsp = s_axi_rresp;
        data = s_axi_rdata;
        s_axi_rready <= 1'b0;
      end
    end
    if (rsp === 2'h3) num_errors++;
    @(posedge core_clk);
  endtask

  // the pulse check comes only once per 4000-cycle period, so the wait is generous
  task automatic waitRed(input logic val);
    int n;
    n = 0;
    while (ledRed[0] !== val && n < 9000) begin
      @(posedge core_clk);
      n++;
    end
    check(32'(ledRed[0]), 32'(val));
  endtask

  // watchdog sized well above the three 4000-cycle pulse periods the tests need
  initial begin
    repeat (60000) @(posedge core_clk);
    num_errors++;
    complete_run();
  end

  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    axiRead(8'h00, rd, resp);
    check(rd, 32'h1911_0901);
    axiWrite(8'h20, 32'h1, resp);
    check(32'(resp), 32'(sis_pkg::RESP_SLVERR));
    axiRead(8'h20, rd, resp);
    check(32'(resp), 32'(sis_pkg::RESP_SLVERR));
    // diagnosis off everywhere so the truth tables see the levels directly
    axiWrite(8'h00, 32'h1810_0800, resp);
    for (int i = 0; i < 8; i++) begin
      closed <= 4'h0;
      axiWrite(8'h04, {4{4'h1, 2'b00, rows[i][5:4]}}, resp);
      closed <= {2'b00, rows[i][3:2]};
      repeat (4) @(posedge core_clk);
      check(32'(safeData[1:0]), 32'(rows[i][1:0]));
      check(32'(ledYellow[1:0]), 32'(rows[i][3:2]));
    end
    axiWrite(8'h04, 32'h3030_3030, resp);
    axiRead(8'h04, rd, resp);
    check(rd, 32'h1010_1010);
    // discrepancy: only the even input closes, code 2 gives 16 cycles
    closed <= 4'h0;
    axiWrite(8'h14, 32'h0000_0100, resp);
    axiWrite(8'h04, 32'h2121_2121, resp);
    closed <= 4'h1;
    repeat (12) @(posedge core_clk);
    check(32'(ledRed[1:0]), 32'h0);
    repeat (14) @(posedge core_clk);
    check(32'(ledRed[1:0]), 32'h3);
    check(32'(irq), 32'h1);
    closed <= 4'h3;
    repeat (4) @(posedge core_clk);
    check(32'(safeData[1:0]), 32'h0);
    axiRead(8'h0C, rd, resp);
    check(32'(rd[16]), 32'h1);
    closed <= 4'h0;
    repeat (4) @(posedge core_clk);
    closed <= 4'h3;
    repeat (4) @(posedge core_clk);
    check(32'(safeData[1:0]), 32'h1);
    check(32'(ledRed[1:0]), 32'h3);
    axiWrite(8'h10, 32'h0000_0100, resp);
    repeat (3) @(posedge core_clk);
    check(32'(irq), 32'h0);
    // stuck-high input under the contact waveform must be caught and then clear on recovery
    closed <= 4'h0;
    axiWrite(8'h04, 32'h1010_1010, resp);
    axiWrite(8'h00, 32'h1911_0901, resp);
    waitRed(1'b0);
    stuck <= 4'h1;
    waitRed(1'b1);
    check(32'(safeData[0]), 32'h0);
    stuck <= 4'h0;
    closed <= 4'h1;
    waitRed(1'b0);
    repeat (3) @(posedge core_clk);
    check(32'(safeData[0]), 32'h1);
    // beam waveform: the next whole pulse on output 0 must last the beam low time
    axiWrite(8'h00, 32'h1911_0903, resp);
    while (testOut[0] === 1'b0) @(posedge core_clk);
    while (testOut[0] === 1'b1 && lowCnt < 9000) begin
      @(posedge core_clk);
      lowCnt++;
    end
    lowCnt = 0;
    while (testOut[0] === 1'b0 && lowCnt < 9000) begin
      @(posedge core_clk);
      lowCnt++;
    end
    check(32'(lowCnt), 32'(sis_pkg::TP_LOW_BEAM_US * sis_pkg::CLK_MHZ));
    // reset in mid-run: outputs go back to idle and the mask to zero
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    check(32'({testOut, ledRed, safeData, 3'b000, irq}), 32'h0000_F000);
    axiRead(8'h14, rd, resp);
    check(rd, 32'h0000_0000);
    complete_run();
  end
endmodule
